// ---- hdl/tcrb_pkg.sv ----
// shared constants and types of the transceiver configuration register bank
`default_nettype none
package tcrb_pkg;
  localparam int unsigned REG_COUNT = 32;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 26;
  localparam int unsigned FRAME_W = 32;
  localparam int unsigned CNT_W = 6;
  // serial frame layout
  localparam int unsigned RW_BIT = 31;
  localparam int unsigned ADDR_MSB = 30;
  localparam int unsigned ADDR_LSB = 26;
  // link bit counter checkpoints, counted in rising edges already seen
  localparam logic [5:0] CNT_ZERO = 6'h00;
  localparam logic [5:0] CNT_HDR_LAST = 6'h05;
  localparam logic [5:0] CNT_RD_LOAD = 6'h07;
  localparam logic [5:0] CNT_FRAME_LAST = 6'h1F;
  localparam logic [5:0] CNT_FRAME_END = 6'h20;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  // register addresses
  localparam logic [4:0] ADDR_RECEIVE_BLOCK_ENABLES = 5'h00;
  localparam logic [4:0] ADDR_RECEIVE_GAIN_CONTROL = 5'h01;
  localparam logic [4:0] ADDR_RESERVED_SLOT_2 = 5'h02;
  localparam logic [4:0] ADDR_FRONT_AMP_BIAS_SYNTH_CFG = 5'h03;
  localparam logic [4:0] ADDR_RESERVED_SLOT_4 = 5'h04;
  localparam logic [4:0] ADDR_RESERVED_SLOT_5 = 5'h05;
  localparam logic [4:0] ADDR_RECEIVE_LOWPASS_CFG = 5'h06;
  localparam logic [4:0] ADDR_GENERAL_OUTPUT_CFG = 5'h07;
  localparam logic [4:0] ADDR_RESERVED_SLOT_8 = 5'h08;
  localparam logic [4:0] ADDR_RESERVED_SLOT_9 = 5'h09;
  localparam logic [4:0] ADDR_RECEIVE_SYNTH_FRACTION = 5'h0A;
  localparam logic [4:0] ADDR_RECEIVE_SYNTH_CFG = 5'h0B;
  localparam logic [4:0] ADDR_CONVERTER_CLOCK_OUT_CFG = 5'h0C;
  localparam logic [4:0] ADDR_RESERVED_SLOT_13 = 5'h0D;
  localparam logic [4:0] ADDR_CONVERTER_CLOCK_FRACTION = 5'h0E;
  localparam logic [4:0] ADDR_CONVERTER_CLOCK_SYNTH_CFG = 5'h0F;
  localparam logic [4:0] ADDR_CONVERTER_CLOCK_DITHER = 5'h10;
  localparam logic [4:0] ADDR_CONVERTER_CLOCK_MISC = 5'h11;
  localparam logic [4:0] ADDR_TRANSMIT_LOWPASS_CFG = 5'h12;
  localparam logic [4:0] ADDR_PA_DRIVER_CFG = 5'h13;
  localparam logic [4:0] ADDR_UPCONVERTER_BIAS = 5'h14;
  localparam logic [4:0] ADDR_UPCONVERTER_BIAS_ADJUST = 5'h15;
  localparam logic [4:0] ADDR_UPCONVERTER_OFFSET_ADJUST = 5'h16;
  localparam logic [4:0] ADDR_TRANSMIT_GAIN_SETTING = 5'h17;
  localparam logic [4:0] ADDR_TRANSMIT_GAIN_CURVE = 5'h18;
  localparam logic [4:0] ADDR_RESERVED_SLOT_25 = 5'h19;
  localparam logic [4:0] ADDR_RESERVED_SLOT_26 = 5'h1A;
  localparam logic [4:0] ADDR_TRANSMIT_SYNTH_FRACTION = 5'h1B;
  localparam logic [4:0] ADDR_TRANSMIT_SYNTH_CFG = 5'h1C;
  localparam logic [4:0] ADDR_REFERENCE_IO_CFG = 5'h1D;
  localparam logic [4:0] ADDR_FREQUENCY_TRIM_DAC_WORD = 5'h1E;
  localparam logic [4:0] ADDR_RESERVED_SLOT_31 = 5'h1F;
  // fields of receive_gain_control
  localparam int unsigned AMP_GAIN_LSB = 8;
  localparam int unsigned AMP_GAIN_MSB = 11;
  localparam int unsigned MIX_SW_LSB = 4;
  localparam int unsigned MIX_SW_MSB = 5;
  localparam int unsigned MIX_BAND_BIT = 0;
  localparam int unsigned FRONT_GAIN_LSB = 14;
  localparam int unsigned FRONT_GAIN_MSB = 15;
  localparam logic [5:0] GAIN_STEP_DB = 6'h03;
  localparam logic [1:0] SW_NONE = 2'h3;
  localparam logic [1:0] SW_DCS = 2'h0;
  localparam logic [1:0] SW_PCS = 2'h1;
  localparam logic [1:0] SW_IMT = 2'h2;
  typedef enum logic [2:0] {
    MIX_NONE = 3'h0,
    MIX_CELL = 3'h1,
    MIX_GSM = 3'h2,
    MIX_DCS = 3'h3,
    MIX_PCS = 3'h4,
    MIX_IMT = 3'h5
  } tcrb_mix_t;
  typedef enum logic [1:0] {
    FA_LOW = 2'h0,
    FA_MID = 2'h1,
    FA_HIGH = 2'h2,
    FA_BAD = 2'h3
  } tcrb_fa_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_HOLD = 2'b11
  } tcrb_state_t;
endpackage
`default_nettype wire

// ---- hdl/tcrb_sync.sv ----
// two-flop level synchroniser into the system clock domain
`default_nettype none
module tcrb_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset
  input wire logic ce, // clock enable
  input wire logic asyncIn, // level from another domain
  output logic syncOut // synchronised level
);
  logic meta_r;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_r <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else if (ce) begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/tcrb_regmem.sv ----
// 32 x 26 configuration store with registered read data
`default_nettype none
module tcrb_regmem
  import tcrb_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic ce, // clock enable
  input wire logic wrEn, // write strobe
  input wire logic [ADDR_W-1:0] wrAddr, // write address
  input wire logic [DATA_W-1:0] wrData, // write data
  input wire logic rdEn, // read strobe
  input wire logic [ADDR_W-1:0] rdAddr, // read address
  output logic [DATA_W-1:0] rdData // registered read data
);
  // no reset: contents stay unknown until written
  logic [DATA_W-1:0] mem [REG_COUNT];
  always_ff @(posedge clk_sys) begin
    if (ce && wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (ce && rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule
`default_nettype wire

// ---- hdl/tcrb_top.sv ----
// serial-loaded configuration register bank of the transceiver
//
// How it works
// - There are 32 registers of 26 bits, picked by a 5-bit address, and they set the whole mode.
// - Nothing is defined at power-up, so the host programs every register before use.
// - The 4-bit amplifier gain code runs from minimum at 0000 up in 3 dB steps to 1111.
// - With band choice 0 the switch code gives none for 11, cell for X0 and GSM for X1.
// - With band choice 1 the switch code gives DCS, PCS, IMT and none for 00, 01, 10, 11.
// - Front amp gain decodes 00 low, 01 mid, 10 high, and the host never writes 11.
// - The two synthesizer fractions sit at 01010 and 11011, each decoded only there.
// - A frame is read/write bit, 5 address bits, 26 data bits, MSB first, on rising edges.
// - At the rising edge of chip select the 26 data bits load the addressed register.
// - A read frame shifts the addressed register out, changing on falling edges.
// - No register is cleared at power-up or reset.
`default_nettype none
module tcrb_top
  import tcrb_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic ce, // clock enable of the system domain
  input wire logic linkClk, // serial clock from the host
  input wire logic csN, // chip select, active low
  input wire logic din, // serial data in
  output logic dout, // serial readback data
  output logic doutOe, // readback driver enable
  output logic [REG_COUNT-1:0] cfgLoaded, // one bit per register written since reset
  output logic writeStrobe, // pulse when a register is loaded
  output logic [ADDR_W-1:0] writeAddr, // address of the last load
  output logic frameError, // pulse on a write frame of wrong length
  output logic [3:0] rxAmpGainCode, // receive amplifier gain code
  output logic [5:0] rxAmpGainDb, // gain above minimum in dB
  output tcrb_mix_t mixerInput, // selected mixer input
  output tcrb_fa_t frontAmpGain, // front amplifier gain setting
  output logic frontAmpCodeBad, // forbidden front gain code loaded
  output logic [DATA_W-1:0] rxSynthFraction, // receive synthesizer fraction word
  output logic [DATA_W-1:0] txSynthFraction, // transmit synthesizer fraction word
  output logic [DATA_W-1:0] trimDacWord // frequency trim converter word
);
  // ---------------- link domain ----------------
  logic [CNT_W-1:0] bitCnt;
  logic [FRAME_W-2:0] shiftIn;
  logic [FRAME_W-1:0] frameWord;
  logic frameDone;
  logic rdReq;
  logic frameLive;
  logic [ADDR_W-1:0] rdAddrLink;
  logic [DATA_W-1:0] outShift;
  logic [DATA_W-1:0] rdData;
  logic [FRAME_W-1:0] shiftNext;
  assign shiftNext = {shiftIn, din};

  // count rising edges of a frame
  always_ff @(posedge linkClk or posedge csN) begin
    if (csN) begin
      bitCnt <= CNT_ZERO;
    end else if (bitCnt != CNT_MAX) begin
      bitCnt <= bitCnt + 6'h01;
    end
  end

  // shift in, most significant bit first
  always_ff @(posedge linkClk) begin
    shiftIn <= shiftNext[FRAME_W-2:0];
  end

  // frame word freezes after exactly 32 bits; sclk is still while chip select is high
  always_ff @(posedge linkClk) begin
    if (bitCnt == CNT_FRAME_LAST) begin
      frameWord <= shiftNext;
      frameDone <= 1'b1;
    end else if (bitCnt == CNT_ZERO || bitCnt >= CNT_FRAME_END) begin
      frameDone <= 1'b0;
    end
  end

  // read request raised once the address is complete
  always_ff @(posedge linkClk or posedge csN) begin
    if (csN) begin
      rdReq <= 1'b0;
    end else if (bitCnt == CNT_HDR_LAST) begin
      rdReq <= shiftIn[ADDR_W-1];
    end
  end

  // address stands for the rest of the frame, so the fetch may read it directly
  always_ff @(posedge linkClk) begin
    if (bitCnt == CNT_HDR_LAST) begin
      rdAddrLink <= shiftNext[ADDR_W-1:0];
    end
  end

  // high from the first rising edge until chip select returns high
  always_ff @(posedge linkClk or posedge csN) begin
    if (csN) begin
      frameLive <= 1'b0;
    end else begin
      frameLive <= 1'b1;
    end
  end

  // readback changes on falling edges, one turnaround bit after the address
  // rdData crosses unsynchronised: the fetch settles long before this edge
  always_ff @(negedge linkClk or posedge csN) begin
    if (csN) begin
      outShift <= '0;
      doutOe <= 1'b0;
    end else if (bitCnt == CNT_RD_LOAD && rdReq) begin
      outShift <= rdData;
      doutOe <= 1'b1;
    end else begin
      outShift <= {outShift[DATA_W-2:0], 1'b0};
    end
  end
  assign dout = outShift[DATA_W-1];

  // ---------------- system domain ----------------
  logic csLvl;
  logic rdLvl;
  logic csPrev_r;
  logic rdPrev_r;
  logic liveLvl;
  logic gotEdges_r;
  tcrb_state_t state_r;
  tcrb_state_t state_nxt;

  tcrb_sync #(.RESET_VAL(1'b1)) csSyncInst (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .asyncIn(csN),
    .syncOut(csLvl)
  );

  tcrb_sync #(.RESET_VAL(1'b0)) rdSyncInst (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .asyncIn(rdReq),
    .syncOut(rdLvl)
  );

  tcrb_sync #(.RESET_VAL(1'b0)) liveSyncInst (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .asyncIn(frameLive),
    .syncOut(liveLvl)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      csPrev_r <= 1'b1;
      rdPrev_r <= 1'b0;
    end else if (ce) begin
      csPrev_r <= csLvl;
      rdPrev_r <= rdLvl;
    end
  end

  wire csRise = csLvl & ~csPrev_r;
  wire rdRise = rdLvl & ~rdPrev_r;
  // frame word is stable here: the host has stopped the serial clock
  wire frameIsWrite = frameDone & gotEdges_r & ~frameWord[RW_BIT];
  // load on the chip select rising edge
  wire memWrEn = csRise & frameIsWrite;
  wire [ADDR_W-1:0] memWrAddr = frameWord[ADDR_MSB:ADDR_LSB];
  wire [DATA_W-1:0] memWrData = frameWord[DATA_W-1:0];
  wire memRdEn = (state_r == ST_FETCH);
  wire badFrame = csRise & ~(frameDone & gotEdges_r) & (state_r == ST_IDLE);

  // a select pulse with no clock edges must not replay the last frame word
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gotEdges_r <= 1'b0;
    end else if (ce) begin
      if (liveLvl) begin
        gotEdges_r <= 1'b1;
      end else if (csRise) begin
        gotEdges_r <= 1'b0;
      end
    end
  end

  // fetch the addressed word for the link
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (rdRise) begin
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: begin
        state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        if (csRise) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // one 26-bit word per 5-bit address
  tcrb_regmem memInst (
    .clk_sys(clk_sys),
    .ce(ce),
    .wrEn(memWrEn),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdEn(memRdEn),
    .rdAddr(rdAddrLink),
    .rdData(rdData)
  );

  // shadow copies of the registers whose fields drive outputs; never reset
  logic [DATA_W-1:0] gainShadow;
  logic [DATA_W-1:0] rxFracShadow;
  logic [DATA_W-1:0] txFracShadow;
  logic [DATA_W-1:0] trimShadow;
  // each fraction decoded only at its own address
  wire wrGain = memWrEn & (memWrAddr == ADDR_RECEIVE_GAIN_CONTROL);
  wire wrRxFrac = memWrEn & (memWrAddr == ADDR_RECEIVE_SYNTH_FRACTION);
  wire wrTxFrac = memWrEn & (memWrAddr == ADDR_TRANSMIT_SYNTH_FRACTION);
  wire wrTrim = memWrEn & (memWrAddr == ADDR_FREQUENCY_TRIM_DAC_WORD);

  // held until the own address is written
  always_ff @(posedge clk_sys) begin
    if (ce && wrGain) begin
      gainShadow <= memWrData;
    end
    if (ce && wrRxFrac) begin
      rxFracShadow <= memWrData;
    end
    if (ce && wrTxFrac) begin
      txFracShadow <= memWrData;
    end
    if (ce && wrTrim) begin
      trimShadow <= memWrData;
    end
  end

  // field decode
  wire [3:0] ampCode = gainShadow[AMP_GAIN_MSB:AMP_GAIN_LSB];
  wire [1:0] swCode = gainShadow[MIX_SW_MSB:MIX_SW_LSB];
  wire bandPcs = gainShadow[MIX_BAND_BIT];
  wire [1:0] faCode = gainShadow[FRONT_GAIN_MSB:FRONT_GAIN_LSB];
  // 3 dB per code step above minimum
  wire [5:0] ampDb = {2'h0, ampCode} * GAIN_STEP_DB;
  tcrb_mix_t mixCell;
  tcrb_mix_t mixPcs;
  tcrb_mix_t mixSel;
  assign mixCell = (swCode == SW_NONE) ? MIX_NONE : (swCode[0] ? MIX_GSM : MIX_CELL);
  assign mixPcs = (swCode == SW_DCS) ? MIX_DCS :
                  (swCode == SW_PCS) ? MIX_PCS :
                  (swCode == SW_IMT) ? MIX_IMT : MIX_NONE;
  assign mixSel = bandPcs ? mixPcs : mixCell;
  // front gain code, 11 flagged as forbidden
  wire faBad = (faCode == FA_BAD);

  wire gainLoaded = cfgLoaded[ADDR_RECEIVE_GAIN_CONTROL];
  wire rxFracLoaded = cfgLoaded[ADDR_RECEIVE_SYNTH_FRACTION];
  wire txFracLoaded = cfgLoaded[ADDR_TRANSMIT_SYNTH_FRACTION];
  wire trimLoaded = cfgLoaded[ADDR_FREQUENCY_TRIM_DAC_WORD];

  // status and loaded map
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfgLoaded <= '0;
      writeStrobe <= 1'b0;
      writeAddr <= '0;
      frameError <= 1'b0;
    end else if (ce) begin
      writeStrobe <= memWrEn;
      frameError <= badFrame;
      if (memWrEn) begin
        cfgLoaded[memWrAddr] <= 1'b1;
        writeAddr <= memWrAddr;
      end
    end
  end

  // decoded outputs, zero until their register has been loaded
  wire [3:0] rxAmpGainCode_nxt = gainLoaded ? ampCode : 4'h0;
  wire [5:0] rxAmpGainDb_nxt = gainLoaded ? ampDb : 6'h00;
  tcrb_mix_t mixerInput_nxt;
  tcrb_fa_t frontAmpGain_nxt;
  assign mixerInput_nxt = gainLoaded ? mixSel : MIX_NONE;
  assign frontAmpGain_nxt = gainLoaded ? tcrb_fa_t'(faCode) : FA_LOW;
  wire frontAmpCodeBad_nxt = gainLoaded & faBad;
  wire [DATA_W-1:0] rxSynthFraction_nxt = rxFracLoaded ? rxFracShadow : '0;
  wire [DATA_W-1:0] txSynthFraction_nxt = txFracLoaded ? txFracShadow : '0;
  wire [DATA_W-1:0] trimDacWord_nxt = trimLoaded ? trimShadow : '0;

  // outputs follow a load one cycle after the write strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rxAmpGainCode <= '0;
      rxAmpGainDb <= '0;
      mixerInput <= MIX_NONE;
      frontAmpGain <= FA_LOW;
      frontAmpCodeBad <= 1'b0;
    end else if (ce) begin
      rxAmpGainCode <= rxAmpGainCode_nxt;
      rxAmpGainDb <= rxAmpGainDb_nxt;
      mixerInput <= mixerInput_nxt;
      frontAmpGain <= frontAmpGain_nxt;
      frontAmpCodeBad <= frontAmpCodeBad_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rxSynthFraction <= '0;
      txSynthFraction <= '0;
      trimDacWord <= '0;
    end else if (ce) begin
      rxSynthFraction <= rxSynthFraction_nxt;
      txSynthFraction <= txSynthFraction_nxt;
      trimDacWord <= trimDacWord_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- sim/tcrb_host.sv ----
// host controller model driving the serial link
`default_nettype none
module tcrb_host (
  output logic linkClk, // serial clock
  output logic csN, // chip select
  output logic din, // serial data
  input wire logic dout, // readback data
  input wire logic doutOe // readback enable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    linkClk = 1'b0;
    csN = 1'b1;
    din = 1'b0;
  end
  // msb first, clock still outside frames
  task automatic frame(input logic [32:0] bits, input int n, output logic [25:0] q,
    output logic oe);
    int i;
    q = '0;
    oe = 1'b1;
    #3 csN = 1'b0;
    for (i = 0; i < n; i++) begin
      din = bits[32-i];
      #40 linkClk = 1'b1;
      // readback taken on rising edges 8 to 33
      if (i > 6) begin
        q = {q[24:0], dout};
        oe &= doutOe;
      end
      #40 linkClk = 1'b0;
    end
    #40 csN = 1'b1;
    // released line shows the inverse of the last bit
    din = ~din;
  endtask
endmodule
`default_nettype wire

// ---- sim/tcrb_top_chk.sv ----
// port assertions of the register bank
`default_nettype none
module tcrb_top_chk
  import tcrb_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic srst, // reset
  input wire logic csN, // select
  input wire logic dout, // readback
  input wire logic doutOe, // readback enable
  input wire logic [REG_COUNT-1:0] cfgLoaded, // loaded bits
  input wire logic writeStrobe, // load pulse
  input wire logic [ADDR_W-1:0] writeAddr, // load address
  input wire logic frameError, // bad frame
  input wire logic [3:0] rxAmpGainCode, // gain code
  input wire logic [5:0] rxAmpGainDb, // gain in dB
  input wire tcrb_fa_t frontAmpGain, // front gain
  input wire logic frontAmpCodeBad, // bad front code
  input wire logic [DATA_W-1:0] rxSynthFraction, // rx fraction
  input wire logic [DATA_W-1:0] txSynthFraction, // tx fraction
  input wire logic [DATA_W-1:0] trimDacWord // trim word
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  a_strobe_pulse: assert property (writeStrobe |=> !writeStrobe)
    else $error("load strobe too wide");
  a_strobe_after_cs: assert property (writeStrobe |-> $past(csN, 3) && $past(csN, 2))
    else $error("load without select rise");
  a_strobe_marks_bit: assert property (writeStrobe |-> cfgLoaded[writeAddr])
    else $error("loaded bit missing");
  a_loaded_sticky: assert property (!$past(srst) |->
    (cfgLoaded & $past(cfgLoaded)) == $past(cfgLoaded))
    else $error("loaded bit lost");
  a_gain_db_step: assert property (rxAmpGainDb == 6'(rxAmpGainCode) * GAIN_STEP_DB)
    else $error("gain dB wrong");
  a_front_bad_flag: assert property (frontAmpCodeBad == (frontAmpGain == FA_BAD))
    else $error("front flag wrong");
  a_rx_frac_own: assert property ($changed(rxSynthFraction) && !$past(srst) |->
    $past(writeStrobe) && writeAddr == ADDR_RECEIVE_SYNTH_FRACTION)
    else $error("rx fraction moved");
  a_tx_frac_own: assert property ($changed(txSynthFraction) && !$past(srst) |->
    $past(writeStrobe) && writeAddr == ADDR_TRANSMIT_SYNTH_FRACTION)
    else $error("tx fraction moved");
  a_trim_word_own: assert property ($changed(trimDacWord) && !$past(srst) |->
    $past(writeStrobe) && writeAddr == ADDR_FREQUENCY_TRIM_DAC_WORD)
    else $error("trim word moved");
  a_error_no_load: assert property (frameError |-> !writeStrobe ##1 !frameError)
    else $error("bad frame loaded");
  a_idle_quiet: assert property (csN && $past(csN) |-> !doutOe && !dout)
    else $error("readback while idle");
endmodule
bind tcrb_top tcrb_top_chk chk_u (.clk_sys(clk_sys), .srst(srst), .csN(csN), .dout(dout),
  .doutOe(doutOe), .cfgLoaded(cfgLoaded), .writeStrobe(writeStrobe), .writeAddr(writeAddr),
  .frameError(frameError), .rxAmpGainCode(rxAmpGainCode), .rxAmpGainDb(rxAmpGainDb),
  .frontAmpGain(frontAmpGain), .frontAmpCodeBad(frontAmpCodeBad),
  .rxSynthFraction(rxSynthFraction), .txSynthFraction(txSynthFraction),
  .trimDacWord(trimDacWord));
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench of the register bank
`default_nettype none
module tb_top
  import tcrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // reserved default pattern, plain value
  localparam logic [DATA_W-1:0] RSVD_DEF = 26'h0000000;
  logic clk_sys, srst, ce, dout, doutOe, writeStrobe, frameError, frontAmpCodeBad;
  wire logic linkClk, csN, din;
  logic [REG_COUNT-1:0] cfgLoaded, ld;
  logic [ADDR_W-1:0] writeAddr;
  logic [3:0] rxAmpGainCode;
  logic [5:0] rxAmpGainDb;
  tcrb_mix_t mixerInput;
  tcrb_fa_t frontAmpGain;
  logic [DATA_W-1:0] rxSynthFraction, txSynthFraction, trimDacWord;
  logic [DATA_W-1:0] mdl [REG_COUNT];
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int i;
  int seed = 32'hc76365cd;
  tcrb_host host_u (.linkClk(linkClk), .csN(csN), .din(din), .dout(dout), .doutOe(doutOe));
  tcrb_top dut_u (.clk_sys(clk_sys), .srst(srst), .ce(ce), .linkClk(linkClk), .csN(csN),
    .din(din), .dout(dout), .doutOe(doutOe), .cfgLoaded(cfgLoaded),
    .writeStrobe(writeStrobe), .writeAddr(writeAddr), .frameError(frameError),
    .rxAmpGainCode(rxAmpGainCode), .rxAmpGainDb(rxAmpGainDb), .mixerInput(mixerInput),
    .frontAmpGain(frontAmpGain), .frontAmpCodeBad(frontAmpCodeBad),
    .rxSynthFraction(rxSynthFraction), .txSynthFraction(txSynthFraction),
    .trimDacWord(trimDacWord));
  task automatic end_of_test;
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic tcrb_mix_t mix_exp(input logic [DATA_W-1:0] r);
    logic [1:0] s;
    s = r[MIX_SW_MSB:MIX_SW_LSB];
    if (s == SW_NONE)
      return MIX_NONE;
    if (r[MIX_BAND_BIT])
      return s == SW_DCS ? MIX_DCS : s == SW_PCS ? MIX_PCS : MIX_IMT;
    return s[0] ? MIX_GSM : MIX_CELL;
  endfunction
  task automatic chk_out;
    logic [DATA_W-1:0] g;
    g = ld[1] ? mdl[1] : '0;
    chk("gain", rxAmpGainCode, g[AMP_GAIN_MSB:AMP_GAIN_LSB]);
    chk("gaindb", rxAmpGainDb, g[AMP_GAIN_MSB:AMP_GAIN_LSB] * 3);
    chk("mixer", mixerInput, ld[1] ? mix_exp(g) : MIX_NONE);
    chk("front", frontAmpGain, g[FRONT_GAIN_MSB:FRONT_GAIN_LSB]);
    chk("frontbad", frontAmpCodeBad, g[FRONT_GAIN_MSB:FRONT_GAIN_LSB] == 2'h3);
    chk("rxfrac", rxSynthFraction, ld[10] ? mdl[10] : '0);
    chk("txfrac", txSynthFraction, ld[27] ? mdl[27] : '0);
    chk("trim", trimDacWord, ld[30] ? mdl[30] : '0);
    chk("loaded", cfgLoaded, ld);
  endtask
  task automatic wr(input logic [4:0] a, input logic [DATA_W-1:0] d, input int n = 32);
    logic [25:0] q;
    logic oe;
    int k;
    host_u.frame({1'b0, a, d, 1'b0}, n, q, oe);
    for (k = 0; k < 12 && writeStrobe !== 1'b1 && frameError !== 1'b1; k++)
      @(negedge clk_sys);
    if (n == 32) begin
      mdl[a] = d;
      ld[a] = 1'b1;
      chk("strobe", writeStrobe, 1);
      chk("waddr", writeAddr, a);
    end else begin
      chk("ferr", frameError, 1);
      chk("nostrobe", writeStrobe, 0);
    end
    // decoded outputs settle one cycle after the strobe
    @(negedge clk_sys);
    chk_out;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [4:0] a);
    logic [25:0] q;
    logic oe;
    host_u.frame({1'b1, a, 26'($random(seed)), 1'b0}, 33, q, oe);
    chk("rdata", q, mdl[a]);
    chk("rdoe", oe, 1);
    repeat (6) @(negedge clk_sys);
  endtask
  function automatic bit rsvd(input int a);
    return a inside {2, 4, 5, 8, 9, 13, 25, 26, 31};
  endfunction
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      end_of_test;
    end
  end
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    ld = '0;
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    repeat (1000) @(negedge clk_sys);
    for (i = 0; i < REG_COUNT; i++)
      wr(5'(i), rsvd(i) ? RSVD_DEF : 26'($random(seed)));
    for (i = 0; i < REG_COUNT; i++)
      rd(5'(i));
    // every code, front code 11 four times as refusal
    for (i = 0; i < 16; i++)
      wr(ADDR_RECEIVE_GAIN_CONTROL,
        {10'($random(seed)), 2'(i), 2'h0, 4'(i), 2'h0, 2'(i), 3'h0, i[2]});
    wr(ADDR_RECEIVE_SYNTH_FRACTION, 26'($random(seed)));
    wr(ADDR_TRANSMIT_SYNTH_FRACTION, 26'($random(seed)));
    // select pulse with no clock edges loads nothing
    wr(ADDR_TRANSMIT_SYNTH_FRACTION, 26'($random(seed)), 0);
    wr(ADDR_FREQUENCY_TRIM_DAC_WORD, 26'($random(seed)), 31);
    wr(ADDR_FREQUENCY_TRIM_DAC_WORD, 26'($random(seed)), 33);
    rd(ADDR_FREQUENCY_TRIM_DAC_WORD);
    srst = 1'b1;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    ld = '0;
    repeat (3) @(negedge clk_sys);
    chk_out;
    rd(ADDR_TRANSMIT_SYNTH_FRACTION);
    end_of_test;
  end
endmodule
`default_nettype wire
